// file: gpcmp_pkg.sv
// Purpose: Constants for the comparator control logic
// Assumes: 40 MHz system clock, 8-bit register port
// Notes:   Offsets of control and ladder registers are local choices
// Overview of operation
// R1: Control bits [3:1] pick the minus input from pin B7, pin B0, band-gap, ladder, pin A3 or pin A4.
// R2: Control bit 0 picks the plus input from pin B0 or the ladder reference.
// R3: Control bit 4 set inverts the comparator output polarity.
// R4: A read of the control register returns the present comparator result.
// R5: With the pin option on, the result drives pin B0 directly.
// R6: The comparator is off after reset and turns on only when control bit 7 is written one.
// R7: The comparator powers down only when the stop-system instruction powers the device down.
// R8: Control bit 5 set samples the result on each rising edge of the timer2 count clock.
// R9: The sampling clock is the timer2 clock after pre-scaler and scaler, as fed to the counter.
// R10: Ladder register bits 4 and 5 choose the top and bottom ends of the ladder range.
// R11: Ladder bits [3:0] pick one of sixteen equal taps between the chosen ends.
// R12: With both range bits clear the ladder gives VDD/4 plus (tap+1)/32 of VDD.
// R13: Without sync the result follows the polarity-adjusted comparator output with no clocked delay; the code adds 3 flop cycles.
package gpcmp_pkg;
	localparam logic [1:0] GPCMP_CTRL_OFS   = 2'h0;
	localparam logic [1:0] GPCMP_LADDER_OFS = 2'h1;
	localparam int GPCMP_EN_BIT    = 7;
	localparam int GPCMP_PIN_BIT   = 6;
	localparam int GPCMP_SYNC_BIT  = 5;
	localparam int GPCMP_INV_BIT   = 4;
	localparam int GPCMP_MSEL_HI   = 3;
	localparam int GPCMP_MSEL_LO   = 1;
	localparam int GPCMP_PSEL_BIT  = 0;
	localparam int GPCMP_RNG_HI_BIT = 5;
	localparam int GPCMP_RNG_LO_BIT = 4;
	localparam logic [7:0] GPCMP_CTRL_RST   = 8'h00;
	localparam logic [7:0] GPCMP_LADDER_RST = 8'h00;
	localparam logic [7:0] GPCMP_CTRL_WMASK   = 8'hF7;
	localparam logic [7:0] GPCMP_LADDER_WMASK = 8'h3F;
	typedef enum logic [2:0] {
		GPCMP_M_PORTB_SEVEN = 3'h0,
		GPCMP_M_PORTB_ZERO  = 3'h1,
		GPCMP_M_BG          = 3'h2,
		GPCMP_M_LAD         = 3'h3,
		GPCMP_M_PORTA_THREE = 3'h4,
		GPCMP_M_PORTA_FOUR  = 3'h5
	} gpcmp_msel_e;
endpackage : gpcmp_pkg

// file: gpcmp_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Destination is i_sys_clk
// Notes:   First stage is read only by the second
module gpcmp_sync2 (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_reg;
	logic meta_next;
	logic sync_next;
	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b0;
			o_sync   <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			o_sync   <= sync_next;
		end
	end
endmodule : gpcmp_sync2

// file: gpcmp_edge.sv
// Purpose: Rising edge pulse from a synchronised level
// Assumes: Input already in i_sys_clk domain
// Notes:   One-cycle enable pulse
module gpcmp_edge (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_level,
	output logic      o_rise
);
	logic last_reg;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= i_level;
		end
	end
	assign o_rise = i_level & ~last_reg;
endmodule : gpcmp_edge

// file: gpcmp_ctrl.sv
// Purpose: Control logic of the general purpose comparator
// Assumes: Analog core and ladder live outside; register port is 8 bits wide
// Notes:   Result seen by logic passes a two-flop synchroniser
//
// Added by the designer: the register addresses and the address-and-strobe port.
module gpcmp_ctrl
	import gpcmp_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	input  wire logic       i_stopsys,
	input  wire logic       i_cmp_raw,
	input  wire logic       i_timer2_count_clock,
	output logic            o_cmp_enable,
	output logic            o_cmp_powerdown,
	output logic [2:0]      o_minus_sel,
	output logic            o_plus_sel,
	output logic [1:0]      o_ladder_range,
	output logic [3:0]      o_ladder_tap,
	output logic            o_portb_pin_zero_out,
	output logic            o_portb_pin_zero_oe_n,
	output logic            o_result
);
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] ladder_reg;
	logic [7:0] ladder_next;
	logic [7:0] rdata_next;
	logic       pd_reg;
	logic       pd_next;
	logic       held_reg;
	logic       held_next;
	logic       cmp_sync;
	logic       tclk_sync;
	logic       tclk_rise;
	logic       polar;
	logic       result;
	logic [2:0] msel_store_reg;
	logic [2:0] msel_store_next;
	logic       enable_next;
	logic       powerdown_next;
	logic [2:0] minus_sel_next;
	logic       plus_sel_next;
	logic [1:0] ladder_range_next;
	logic [3:0] ladder_tap_next;
	logic       pin_out_next;
	logic       pin_oe_n_next;
	logic       result_next;

	gpcmp_sync2 u_cmp_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_cmp_raw),
		.o_sync    (cmp_sync)
	);

	gpcmp_sync2 u_tclk_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_timer2_count_clock),
		.o_sync    (tclk_sync)
	);

	gpcmp_edge u_tclk_edge (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_level   (tclk_sync),
		.o_rise    (tclk_rise)
	);

	// Polarity applied before either presentation path
	assign polar = cmp_sync ^ ctrl_reg[GPCMP_INV_BIT]; // R3
	// Sync off: combinational pass from polar; the two-flop input synchroniser and the output flop add delay
	assign result = ctrl_reg[GPCMP_SYNC_BIT] ? held_reg : polar; // R8 R13

	always_comb begin
		ctrl_next   = ctrl_reg;
		ladder_next = ladder_reg;
		held_next   = held_reg;
		pd_next     = pd_reg;
		rdata_next  = 8'h00;
		msel_store_next = msel_store_reg;
		if (i_wr && i_addr == GPCMP_CTRL_OFS) begin
			ctrl_next = i_wdata & GPCMP_CTRL_WMASK; // R6 R1 R2
			// Kept apart so the read-only result bit cannot clip the select
			msel_store_next = i_wdata[GPCMP_MSEL_HI:GPCMP_MSEL_LO]; // R1
		end
		if (i_wr && i_addr == GPCMP_LADDER_OFS) begin
			ladder_next = i_wdata & GPCMP_LADDER_WMASK; // R10 R11
		end
		// Sampled only on the post-scaler timer2 clock edge
		if (tclk_rise) begin
			held_next = polar; // R8 R9
		end
		// Power-down tracks the stop-system state alone
		pd_next = i_stopsys; // R7
		if (i_rd) begin
			unique case (i_addr)
				GPCMP_CTRL_OFS:   rdata_next = {ctrl_reg[7:4], result, ctrl_reg[2:0]}; // R4
				GPCMP_LADDER_OFS: rdata_next = ladder_reg;
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	// Bit 3 of the control read is the result; minus select spans [3:1] on write only
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_reg   <= GPCMP_CTRL_RST; // R6
			ladder_reg <= GPCMP_LADDER_RST;
			held_reg   <= 1'b0;
			pd_reg     <= 1'b0;
			o_rdata    <= 8'h00;
			msel_store_reg <= 3'h0;
		end else begin
			ctrl_reg   <= ctrl_next;
			ladder_reg <= ladder_next;
			held_reg   <= held_next;
			pd_reg     <= pd_next;
			o_rdata    <= rdata_next;
			msel_store_reg <= msel_store_next;
		end
	end

	// Output group; every top-level output except o_rdata is a flop fed from here
	always_comb begin
		enable_next       = ctrl_reg[GPCMP_EN_BIT] & ~pd_reg; // R6 R7
		powerdown_next    = pd_reg; // R7
		minus_sel_next    = msel_store_reg; // R1
		plus_sel_next     = ctrl_reg[GPCMP_PSEL_BIT]; // R2
		ladder_range_next = {ladder_reg[GPCMP_RNG_HI_BIT], ladder_reg[GPCMP_RNG_LO_BIT]}; // R10 R12
		ladder_tap_next   = ladder_reg[3:0]; // R11
		pin_out_next      = result; // R5
		pin_oe_n_next     = ~ctrl_reg[GPCMP_PIN_BIT]; // R5
		result_next       = result; // R4 R13
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_cmp_enable          <= 1'b0;
			o_cmp_powerdown       <= 1'b0;
			o_minus_sel           <= 3'h0;
			o_plus_sel            <= 1'b0;
			o_ladder_range        <= 2'h0;
			o_ladder_tap          <= 4'h0;
			o_portb_pin_zero_out  <= 1'b0;
			o_portb_pin_zero_oe_n <= 1'b1;
			o_result              <= 1'b0;
		end else begin
			o_cmp_enable          <= enable_next;
			o_cmp_powerdown       <= powerdown_next;
			o_minus_sel           <= minus_sel_next;
			o_plus_sel            <= plus_sel_next;
			o_ladder_range        <= ladder_range_next;
			o_ladder_tap          <= ladder_tap_next;
			o_portb_pin_zero_out  <= pin_out_next;
			o_portb_pin_zero_oe_n <= pin_oe_n_next;
			o_result              <= result_next;
		end
	end
endmodule : gpcmp_ctrl

// file: gpcmp_ctrl_properties.sv
// Purpose: Port checks for the comparator control logic
// Assumes: Shadow copies of both registers follow the port writes
// Notes:   Read data bit 3 is left to the bench, its timing is loose
module gpcmp_ctrl_chk (
	input wire logic       i_sys_clk,
	input wire logic       i_rst_n,
	input wire logic       i_wr,
	input wire logic       i_stopsys,
	input wire logic       i_cmp_raw,
	input wire logic       i_timer2_count_clock,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       o_cmp_enable,
	input wire logic       o_cmp_powerdown,
	input wire logic       o_plus_sel,
	input wire logic       o_result,
	input wire logic       o_portb_pin_zero_out,
	input wire logic       o_portb_pin_zero_oe_n,
	input wire logic [2:0] o_minus_sel,
	input wire logic [1:0] o_ladder_range,
	input wire logic [3:0] o_ladder_tap
);
	logic [7:0] ctl_reg, lad_reg;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctl_reg <= 8'h00;
			lad_reg <= 8'h00;
		end else if (i_wr && i_addr == 2'h0) ctl_reg <= i_wdata;
		else if (i_wr && i_addr == 2'h1) lad_reg <= i_wdata;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	property p_en; !i_stopsys[*6] |-> o_cmp_enable == $past(ctl_reg[7]); endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_pd; $stable(i_stopsys)[*6] |-> o_cmp_powerdown == i_stopsys; endproperty
	a_pd: assert property (p_pd) else $error("powerdown wrong");
	property p_sel; o_minus_sel == $past(ctl_reg[3:1]) && o_plus_sel == $past(ctl_reg[0]); endproperty
	a_sel: assert property (p_sel) else $error("input select wrong");
	property p_lad; o_ladder_tap == $past(lad_reg[3:0]) && o_ladder_range == $past(lad_reg[5:4]); endproperty
	a_lad: assert property (p_lad) else $error("ladder wrong");
	property p_oe; o_portb_pin_zero_oe_n == !$past(ctl_reg[6]); endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_pin; !o_portb_pin_zero_oe_n |-> o_portb_pin_zero_out == o_result; endproperty
	a_pin: assert property (p_pin) else $error("pin value wrong");
	property p_pin_val;
		(!ctl_reg[5] && ctl_reg[6] && $stable(ctl_reg) && $stable(i_cmp_raw))[*6] |->
			(o_portb_pin_zero_out == (i_cmp_raw ^ ctl_reg[4])) && !o_portb_pin_zero_oe_n;
	endproperty
	a_pin_val: assert property (p_pin_val) else $error("pin drive wrong");
	property p_res;
		(!ctl_reg[5] && $stable(ctl_reg) && $stable(i_cmp_raw))[*6] |-> o_result == (i_cmp_raw ^ ctl_reg[4]);
	endproperty
	a_res: assert property (p_res) else $error("result wrong");
	property p_sync; (ctl_reg[5] && !i_timer2_count_clock && $stable(ctl_reg))[*6] |-> $stable(o_result); endproperty
	a_sync: assert property (p_sync) else $error("sync hold wrong");
	c_sync: cover property (ctl_reg[5] && $rose(o_result));
	c_pd: cover property (o_cmp_powerdown);
	c_inv: cover property (ctl_reg[4] && o_result);
endmodule : gpcmp_ctrl_chk
bind gpcmp_ctrl gpcmp_ctrl_chk i_chk (
	.i_sys_clk             (i_sys_clk),
	.i_rst_n               (i_rst_n),
	.i_wr                  (i_wr),
	.i_stopsys             (i_stopsys),
	.i_cmp_raw             (i_cmp_raw),
	.i_timer2_count_clock  (i_timer2_count_clock),
	.i_addr                (i_addr),
	.i_wdata               (i_wdata),
	.o_cmp_enable          (o_cmp_enable),
	.o_cmp_powerdown       (o_cmp_powerdown),
	.o_plus_sel            (o_plus_sel),
	.o_result              (o_result),
	.o_portb_pin_zero_out  (o_portb_pin_zero_out),
	.o_portb_pin_zero_oe_n (o_portb_pin_zero_oe_n),
	.o_minus_sel           (o_minus_sel),
	.o_ladder_range        (o_ladder_range),
	.o_ladder_tap          (o_ladder_tap)
);

// file: gpcmp_far_model.sv
// Purpose: Analog comparator core and timer2 clock source
// Assumes: Timer clock runs only while asked for
// Notes:   Raw output lags its level by a few ns, unrelated to the clock
module gpcmp_far_model (
	input  wire logic i_sys_clk,
	input  wire logic i_level,
	input  wire logic i_run,
	output logic      o_cmp_raw = 1'b0,
	output logic      o_t2_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_reg = 3'h0;
	always @(posedge i_sys_clk) div_reg <= i_run ? div_reg + 3'h1 : 3'h0;
	assign o_t2_clk = div_reg[2];
	always @(i_level) o_cmp_raw <= #7 i_level;
endmodule : gpcmp_far_model

// file: gpcmp_tb.sv
// Purpose: Self-checking bench for the comparator control logic
// Assumes: Reads answer one cycle after the strobe
// Notes:   Expected read data wait in a queue for the monitor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic       i_stopsys = 1'b0, lvl = 1'b0, run = 1'b0, rd_seen = 1'b0;
	logic [1:0] i_addr = 2'h0, o_ladder_range;
	logic [7:0] i_wdata = 8'h00, o_rdata, d;
	logic [2:0] o_minus_sel;
	logic [3:0] o_ladder_tap;
	logic       i_cmp_raw, i_timer2_count_clock, o_cmp_enable, o_cmp_powerdown, o_plus_sel;
	logic       o_portb_pin_zero_out, o_portb_pin_zero_oe_n, o_result;
	logic [7:0] exp_q[$];
	int         mismatches = 0, tests_run = 0, cyc = 0;
	gpcmp_ctrl i_dut (
		.i_sys_clk             (i_sys_clk),
		.i_rst_n               (i_rst_n),
		.i_addr                (i_addr),
		.i_wdata               (i_wdata),
		.i_wr                  (i_wr),
		.i_rd                  (i_rd),
		.o_rdata               (o_rdata),
		.i_stopsys             (i_stopsys),
		.i_cmp_raw             (i_cmp_raw),
		.i_timer2_count_clock  (i_timer2_count_clock),
		.o_cmp_enable          (o_cmp_enable),
		.o_cmp_powerdown       (o_cmp_powerdown),
		.o_minus_sel           (o_minus_sel),
		.o_plus_sel            (o_plus_sel),
		.o_ladder_range        (o_ladder_range),
		.o_ladder_tap          (o_ladder_tap),
		.o_portb_pin_zero_out  (o_portb_pin_zero_out),
		.o_portb_pin_zero_oe_n (o_portb_pin_zero_oe_n),
		.o_result              (o_result)
	);
	gpcmp_far_model i_far (.i_sys_clk(i_sys_clk), .i_level(lvl), .i_run(run), .o_cmp_raw(i_cmp_raw),
		.o_t2_clk(i_timer2_count_clock));
	initial forever #12.5 i_sys_clk = ~i_sys_clk;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic final_report;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v);
		@(posedge i_sys_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= v;
		if (!w) exp_q.push_back(v);
		@(posedge i_sys_clk);
		{i_wr, i_rd} <= 2'b00;
	endtask : acc
	always @(posedge i_sys_clk) begin
		rd_seen <= i_rd;
		if (rd_seen) chk(o_rdata, exp_q.pop_front());
		else if (i_rst_n) chk(o_rdata, 8'h00);
		if (++cyc == 4000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		void'($urandom(23968));
		repeat (6) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		acc(0, 2'h0, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 6; m++) begin
			d = {1'b1, m[0], 2'b00, m[2:0], m[0]};
			acc(1, 2'h0, d);
			acc(0, 2'h0, d & 8'hF7);
			chk({o_portb_pin_zero_oe_n, 3'h0, o_minus_sel, o_plus_sel}, {~m[0], 3'h0, m[2:0], m[0]});
		end
		$display("test select done");
		acc(1, 2'h0, 8'hD0);
		repeat (8) @(posedge i_sys_clk);
		acc(0, 2'h0, 8'hD8);
		chk({6'h00, o_portb_pin_zero_oe_n, o_portb_pin_zero_out}, 8'h01);
		lvl <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		acc(0, 2'h0, 8'hD0);
		chk({6'h00, o_portb_pin_zero_oe_n, o_portb_pin_zero_out}, 8'h00);
		$display("test polarity done");
		repeat (4) begin
			d = 8'($urandom);
			acc(1, 2'h1, d);
			acc(1, 2'h3, ~d);
			acc(0, 2'h1, d & 8'h3F);
			chk({2'h0, o_ladder_range, o_ladder_tap}, {2'h0, d[5:0]});
			acc(0, 2'h2, 8'h00);
		end
		$display("test ladder done");
		acc(1, 2'h0, 8'hB0);
		repeat (8) @(posedge i_sys_clk);
		lvl <= 1'b0;
		repeat (10) @(posedge i_sys_clk);
		chk({7'h00, o_result}, 8'h00);
		run <= 1'b1;
		repeat (40) @(posedge i_sys_clk);
		run <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		chk({7'h00, o_result}, 8'h01);
		$display("test sync done");
		i_stopsys <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		chk({6'h00, o_cmp_powerdown, o_cmp_enable}, 8'h02);
		i_stopsys <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		chk({6'h00, o_cmp_powerdown, o_cmp_enable}, 8'h01);
		$display("test power done");
		final_report();
	end
endmodule : tb
